/* File: verilog/ieb_bank.sv */
// interrupt enable and priority register bank with two-level arbiter
`timescale 1ns/1ps

// Functional notes
// - global enable low blocks every source regardless of individual masks.
// - global enable high passes a source only when its mask bit is set.
// - bit 6 of basic enable is plain storage with no hardware effect.
// - basic enable bits 5,4,3,1 mask timer2, uart0, timer1, timer0.
// - basic enable bits 2 and 0 mask external pins 1 and 0.
// - basic enable at 0xa8, all pages, bit access, resets to zero.
// - basic priority at 0xb8 mirrors basic enable layout; 1 means high.
// - basic priority top two bits read one, ignore writes; reset 0xc0.
// - first extended enable bit 7 reads zero and ignores writes.
// - first extended enable bits 6..4 mask comparators 2, 1, 0.
// - bits 3..0 mask counter array, adc0 window, smbus, spi0.
// - second extended enable at 0xe7 masks seven sources; bit 7 reserved.
// - adc2 enable bits stay storage when the second converter is absent.
// - first extended priority at 0xf6 holds seven priorities; resets zero.
// - high level preempts low service; high service is never preempted.
// - equal level requests resolve by fixed order, lower number wins.
// - pending requests are sampled and decoded every clock cycle.
// - fastest response is five cycles: one detect, four call.
module ieb_bank
    import ieb_pkg::*;
#(
    parameter bit HAS_ADC2 = 1'b1
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire ieb_sfr_req_t sfr,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    input wire logic [NUM_SRC-1:0] irq_pending,
    input wire logic cpu_accept,
    input wire logic isr_return,
    output ieb_call_t call,
    output logic [NUM_SRC-1:0] req_high,
    output logic [NUM_SRC-1:0] req_low,
    output logic in_service_high,
    output logic in_service_low,
    output logic call_busy
);

    // ****************************************
    // helpers
    // ****************************************

    // replace one bit of a register value
    function automatic logic [7:0] set_bit(input logic [7:0] v, input logic [2:0] sel, input logic val);
        logic [7:0] r;
        r = v;
        r[sel] = val;
        return r;
    endfunction

    // lowest set index wins
    function automatic logic [SRC_W-1:0] first_set(input logic [NUM_SRC-1:0] vec);
        logic [SRC_W-1:0] idx;
        idx = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (vec[i]) begin
                idx = SRC_W'(i);
            end
        end
        return idx;
    endfunction

    // ****************************************
    // register storage
    // ****************************************
    logic [7:0] en_basic;
    logic [7:0] pri_basic;
    logic [7:0] en_ext1;
    logic [7:0] en_ext2;
    logic [7:0] pri_ext1;
    logic bit_basic;

    // bit access only reaches the two basic registers
    assign bit_basic = sfr.bit_wr && (sfr.addr == ADDR_EN_BASIC || sfr.addr == ADDR_PRI_BASIC);

    // basic enable: every bit plain read/write, spare flag included
    always_ff @(posedge core_clk) begin
        if (srst) begin
            en_basic <= RST_EN_BASIC;
        end else if (sfr.wr && sfr.addr == ADDR_EN_BASIC) begin
            en_basic <= sfr.wdata;
        end else if (bit_basic && sfr.addr == ADDR_EN_BASIC) begin
            en_basic <= set_bit(en_basic, sfr.bit_sel, sfr.bit_val);
        end
    end

    // basic priority: top two bits are not stored
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pri_basic <= RST_PRI_BASIC & BASIC_PRI_STORE_MASK;
        end else if (sfr.wr && sfr.addr == ADDR_PRI_BASIC) begin
            pri_basic <= sfr.wdata & BASIC_PRI_STORE_MASK;
        end else if (bit_basic && sfr.addr == ADDR_PRI_BASIC) begin
            pri_basic <= set_bit(pri_basic, sfr.bit_sel, sfr.bit_val) & BASIC_PRI_STORE_MASK;
        end
    end

    // first extended enable: reserved top bit never stored, so it reads zero
    always_ff @(posedge core_clk) begin
        if (srst) begin
            en_ext1 <= RST_EN_EXT1;
        end else if (sfr.wr && sfr.addr == ADDR_EN_EXT1) begin
            en_ext1 <= sfr.wdata & EXT_STORE_MASK;
        end
    end

    // second extended enable: reserved top bit never stored
    always_ff @(posedge core_clk) begin
        if (srst) begin
            en_ext2 <= RST_EN_EXT2;
        end else if (sfr.wr && sfr.addr == ADDR_EN_EXT2) begin
            en_ext2 <= sfr.wdata & EXT_STORE_MASK;
        end
    end

    // first extended priority: reserved top bit never stored
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pri_ext1 <= RST_PRI_EXT1;
        end else if (sfr.wr && sfr.addr == ADDR_PRI_EXT1) begin
            pri_ext1 <= sfr.wdata & EXT_STORE_MASK;
        end
    end

    // ****************************************
    // register read port
    // ****************************************

    // address decode for the answer
    always_comb begin
        sfr_hit = 1'b0;
        case (sfr.addr)
            ADDR_EN_BASIC, ADDR_PRI_BASIC, ADDR_EN_EXT1, ADDR_EN_EXT2, ADDR_PRI_EXT1: begin
                sfr_hit = 1'b1;
            end
            default: begin
                sfr_hit = 1'b0;
            end
        endcase
    end

    // read data one cycle after the strobe, zero when unmapped
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sfr_rdata <= 8'h00;
        end else if (sfr.rd) begin
            case (sfr.addr)
                ADDR_EN_BASIC: begin
                    sfr_rdata <= en_basic;
                end
                ADDR_PRI_BASIC: begin
                    sfr_rdata <= pri_basic | PRI_BASIC_ONES;
                end
                ADDR_EN_EXT1: begin
                    sfr_rdata <= en_ext1;
                end
                ADDR_EN_EXT2: begin
                    sfr_rdata <= en_ext2;
                end
                ADDR_PRI_EXT1: begin
                    sfr_rdata <= pri_ext1;
                end
                default: begin
                    sfr_rdata <= 8'h00;
                end
            endcase
        end
    end

    // ****************************************
    // request gating and level routing
    // ****************************************
    logic [NUM_SRC-1:0] mask_vec;
    logic [NUM_SRC-1:0] pri_vec;
    logic [NUM_SRC-1:0] src_present;
    logic [NUM_SRC-1:0] gated;

    // mask vector in arbitration order; spare flag bit left out
    assign mask_vec = {en_ext2[EXT_SRC_W-1:0], en_ext1[EXT_SRC_W-1:0], en_basic[BASIC_SRC_W-1:0]};
    // second extended priority register absent: those sources run low
    assign pri_vec = {{EXT_SRC_W{1'b0}}, pri_ext1[EXT_SRC_W-1:0], pri_basic[BASIC_SRC_W-1:0]};

    // adc2 sources detached when the converter is absent
    always_comb begin
        src_present = '1;
        src_present[ADC2_WIN_SRC] = HAS_ADC2;
        src_present[ADC2_DONE_SRC] = HAS_ADC2;
    end

    assign gated = irq_pending & mask_vec & src_present & {NUM_SRC{en_basic[GLOBAL_EN_BIT]}};

    // detect stage, sampled each cycle
    // this register is the one detect cycle of the response
    always_ff @(posedge core_clk) begin
        if (srst) begin
            req_high <= '0;
            req_low <= '0;
        end else begin
            req_high <= gated & pri_vec;
            req_low <= gated & ~pri_vec;
        end
    end

    // ****************************************
    // arbitration and call sequencing
    // ****************************************
    ieb_state_t state;
    logic [2:0] call_cnt;
    logic high_ok;
    logic low_ok;
    logic entering;
    logic next_level;
    logic [SRC_W-1:0] next_src;

    // start cycle: the service flag only rises at the next edge, so no pick now
    // without this a source still pending would be called a second time
    assign entering = call.start;

    // high waits only on high service; low waits on any service
    assign high_ok = (|req_high) && !in_service_high && !entering;
    assign low_ok = (|req_low) && !in_service_high && !in_service_low && !entering;
    assign call_busy = (state == ST_CALL);

    // winner: high group first, fixed order inside a group
    always_comb begin
        next_level = 1'b0;
        next_src = '0;
        if (high_ok) begin
            next_level = 1'b1;
            next_src = first_set(req_high);
        end else if (low_ok) begin
            next_level = 1'b0;
            next_src = first_set(req_low);
        end
    end

    // pick a winner, then count out the call
    // selection is frozen once counting starts
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state <= ST_IDLE;
            call_cnt <= 3'h0;
            call <= '0;
        end else begin
            call.start <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (cpu_accept && (high_ok || low_ok)) begin
                        call.level <= next_level;
                        call.src <= next_src;
                        call.order <= SRC_ORDER[next_src];
                        call_cnt <= CALL_LOAD;
                        state <= ST_CALL;
                    end
                end
                ST_CALL: begin
                    if (call_cnt == 3'h0) begin
                        call.start <= 1'b1;
                        state <= ST_IDLE;
                    end else begin
                        call_cnt <= call_cnt - 3'h1;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // in-service tracking
    // ****************************************

    // return ends the highest active level; a new entry wins over it
    // a start and a return in one cycle leave the new level set
    always_ff @(posedge core_clk) begin
        if (srst) begin
            in_service_high <= 1'b0;
            in_service_low <= 1'b0;
        end else begin
            if (isr_return) begin
                if (in_service_high) begin
                    in_service_high <= 1'b0;
                end else begin
                    in_service_low <= 1'b0;
                end
            end
            if (call.start && call.level) begin
                in_service_high <= 1'b1;
            end
            if (call.start && !call.level) begin
                in_service_low <= 1'b1;
            end
        end
    end

endmodule

/* File: verilog/ieb_pkg.sv */
// constants and carrier types of the interrupt enable and priority bank
package ieb_pkg;
    // ****************************************
    // register addresses in the core's register space
    // ****************************************
    localparam logic [7:0] ADDR_EN_BASIC = 8'ha8;
    localparam logic [7:0] ADDR_PRI_BASIC = 8'hb8;
    localparam logic [7:0] ADDR_EN_EXT1 = 8'he6;
    localparam logic [7:0] ADDR_EN_EXT2 = 8'he7;
    localparam logic [7:0] ADDR_PRI_EXT1 = 8'hf6;

    // ****************************************
    // reset values and fixed bits
    // ****************************************
    localparam logic [7:0] RST_EN_BASIC = 8'h00;
    localparam logic [7:0] RST_PRI_BASIC = 8'hc0;
    localparam logic [7:0] RST_EN_EXT1 = 8'h00;
    localparam logic [7:0] RST_EN_EXT2 = 8'h00;
    localparam logic [7:0] RST_PRI_EXT1 = 8'h00;
    localparam logic [7:0] PRI_BASIC_ONES = 8'hc0;
    localparam logic [7:0] EXT_STORE_MASK = 8'h7f;
    localparam logic [7:0] BASIC_PRI_STORE_MASK = 8'h3f;

    // ****************************************
    // field positions
    // ****************************************
    localparam int GLOBAL_EN_BIT = 7;
    localparam int SPARE_FLAG_BIT = 6;
    localparam int BASIC_SRC_W = 6;
    localparam int EXT_SRC_W = 7;
    localparam int ADC2_WIN_SRC = 16;
    localparam int ADC2_DONE_SRC = 17;

    // ****************************************
    // sources in arbitration order, and their order numbers
    // ****************************************
    localparam int NUM_SRC = 20;
    localparam int SRC_W = 5;
    localparam logic [SRC_W-1:0] SRC_ORDER [NUM_SRC] = '{
        5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09,
        5'h0a, 5'h0b, 5'h0c, 5'h0e, 5'h0f, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14};

    // ****************************************
    // response timing in core clock cycles
    // ****************************************
    localparam int DETECT_CYCLES = 1;
    localparam int CALL_CYCLES = 4;
    localparam logic [2:0] CALL_LOAD = 3'(CALL_CYCLES - DETECT_CYCLES - 1);

    // ****************************************
    // carrier types
    // ****************************************
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic bit_wr;
        logic [2:0] bit_sel;
        logic bit_val;
        logic [7:0] wdata;
    } ieb_sfr_req_t;

    typedef struct packed {
        logic start;
        logic level;
        logic [SRC_W-1:0] src;
        logic [SRC_W-1:0] order;
    } ieb_call_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CALL = 2'b10
    } ieb_state_t;
endpackage

/* File: bench/ieb_chk.sv */
// assertion checker bound to the interrupt enable and priority bank
`timescale 1ns/1ps
module ieb_chk
    import ieb_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire ieb_sfr_req_t sfr,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_hit,
    input wire logic [NUM_SRC-1:0] irq_pending,
    input wire logic cpu_accept,
    input wire logic isr_return,
    input wire ieb_call_t call,
    input wire logic [NUM_SRC-1:0] req_high,
    input wire logic [NUM_SRC-1:0] req_low,
    input wire logic in_service_high,
    input wire logic in_service_low,
    input wire logic call_busy
);
    logic global_en_shadow;
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    // ****************************************
    // shadow of the global enable, byte write wins over bit write
    // ****************************************
    always_ff @(posedge core_clk) begin
        if (srst) begin
            global_en_shadow <= 1'b0;
        end else if (sfr.wr && sfr.addr == ADDR_EN_BASIC) begin
            global_en_shadow <= sfr.wdata[GLOBAL_EN_BIT];
        end else if (sfr.bit_wr && sfr.addr == ADDR_EN_BASIC && sfr.bit_sel == 3'h7) begin
            global_en_shadow <= sfr.bit_val;
        end
    end
    // lowest set index wins a tie
    function automatic logic [SRC_W-1:0] lowest(input logic [NUM_SRC-1:0] v);
        lowest = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                lowest = SRC_W'(i);
            end
        end
    endfunction
    property p_global_off;
        !$past(global_en_shadow) |-> (req_high | req_low) == '0;
    endproperty
    a_global_off: assert property (p_global_off) else $error("request passed while globally disabled");
    property p_req_cause;
        ((req_high | req_low) & ~$past(irq_pending)) == '0;
    endproperty
    a_req_cause: assert property (p_req_cause) else $error("request without pending flag");
    property p_split;
        (req_high & req_low) == '0;
    endproperty
    a_split: assert property (p_split) else $error("source in both groups");
    property p_latency;
        $rose(call_busy) |-> call_busy [*3] ##1 (call.start && !call_busy);
    endproperty
    a_latency: assert property (p_latency) else $error("call not started four cycles after detect");
    property p_pick;
        $rose(call_busy) |-> call.level == ($past(req_high) != '0)
            && call.src == lowest(call.level ? $past(req_high) : $past(req_low));
    endproperty
    a_pick: assert property (p_pick) else $error("wrong source selected");
    property p_order;
        $rose(call_busy) |-> call.order == SRC_ORDER[call.src];
    endproperty
    a_order: assert property (p_order) else $error("wrong order number");
    property p_high_held;
        call.start |-> !in_service_high;
    endproperty
    a_high_held: assert property (p_high_held) else $error("high service preempted");
    property p_enter;
        call.start |=> ($past(call.level) ? in_service_high : in_service_low);
    endproperty
    a_enter: assert property (p_enter) else $error("service level not entered");
    property p_pri_ones;
        sfr.rd && sfr.addr == ADDR_PRI_BASIC |=> sfr_rdata[7:6] == 2'b11;
    endproperty
    a_pri_ones: assert property (p_pri_ones) else $error("priority top bits not ones");
    property p_ext_top;
        sfr.rd && (sfr.addr == ADDR_EN_EXT1 || sfr.addr == ADDR_EN_EXT2) |=> !sfr_rdata[7];
    endproperty
    a_ext_top: assert property (p_ext_top) else $error("reserved enable bit reads one");
    c_high_call: cover property ($rose(call_busy) && call.level);
    c_preempt: cover property (call.start && call.level && in_service_low);
    c_bit_write: cover property (sfr.bit_wr && sfr.addr == ADDR_EN_BASIC);
endmodule
bind ieb_bank ieb_chk ieb_chk_i (.core_clk(core_clk), .srst(srst), .sfr(sfr), .sfr_rdata(sfr_rdata),
    .sfr_hit(sfr_hit), .irq_pending(irq_pending), .cpu_accept(cpu_accept), .isr_return(isr_return),
    .call(call), .req_high(req_high), .req_low(req_low), .in_service_high(in_service_high),
    .in_service_low(in_service_low), .call_busy(call_busy));

/* File: bench/ieb_cpu_model.sv */
// behavioural core that takes calls and returns from service
`timescale 1ns/1ps
module ieb_cpu_model (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic call_start,
    input wire logic slow,
    output logic cpu_accept,
    output logic isr_return
);
    logic [1:0] depth;
    logic [3:0] left;
    logic [1:0] tick;
    // slow core reaches an instruction boundary one cycle in four
    always_ff @(posedge core_clk) begin
        tick <= srst ? 2'h0 : tick + 2'h1;
    end
    assign cpu_accept = !slow || tick == 2'h0;
    // fixed-length service per call, nested calls stack
    always_ff @(posedge core_clk) begin
        isr_return <= 1'b0;
        if (srst) begin
            depth <= 2'h0;
            left <= 4'h0;
        end else if (call_start) begin
            depth <= depth + 2'h1;
            left <= 4'hc;
        end else if (depth != 2'h0 && left == 4'h0) begin
            isr_return <= 1'b1;
            depth <= depth - 2'h1;
            left <= 4'hc;
        end else if (left != 4'h0) begin
            left <= left - 4'h1;
        end
    end
endmodule

/* File: bench/testbench.sv */
// self-checking testbench of the interrupt enable and priority bank
`timescale 1ns/1ps
module testbench;
    import ieb_pkg::*;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic slow = 1'b0;
    ieb_sfr_req_t sfr = '0;
    logic [NUM_SRC-1:0] irq_pending = '0;
    logic [NUM_SRC-1:0] req_high, req_low;
    logic [7:0] sfr_rdata, d;
    logic sfr_hit, cpu_accept, isr_return, in_service_high, in_service_low, call_busy;
    ieb_call_t call;
    logic [7:0] sh [5];
    logic [7:0] addrs [5] = '{ADDR_EN_BASIC, ADDR_PRI_BASIC, ADDR_EN_EXT1, ADDR_EN_EXT2, ADDR_PRI_EXT1};
    logic [7:0] keep [5] = '{8'hff, 8'h3f, 8'h7f, 8'h7f, 8'h7f};
    logic [7:0] ones [5] = '{RST_EN_BASIC, RST_PRI_BASIC, RST_EN_EXT1, RST_EN_EXT2, RST_PRI_EXT1};
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    int k, n;
    ieb_bank ieb_bank_i (.core_clk(core_clk), .srst(srst), .sfr(sfr), .sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit),
        .irq_pending(irq_pending), .cpu_accept(cpu_accept), .isr_return(isr_return), .call(call),
        .req_high(req_high), .req_low(req_low), .in_service_high(in_service_high),
        .in_service_low(in_service_low), .call_busy(call_busy));
    ieb_cpu_model ieb_cpu_model_i (.core_clk(core_clk), .srst(srst), .call_start(call.start), .slow(slow),
        .cpu_accept(cpu_accept), .isr_return(isr_return));
    // ****************************************
    // clock, hang guard and shared tasks
    // ****************************************
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        if (mismatches == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input logic [19:0] got, input logic [19:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input int i, input logic [7:0] v);
        @(negedge core_clk);
        sfr.addr = addrs[i];
        sfr.wdata = v;
        sfr.wr = 1'b1;
        @(negedge core_clk);
        sfr.wr = 1'b0;
        sh[i] = (v & keep[i]) | ones[i];
    endtask
    // bit writes land only on the two basic registers
    task automatic bwr(input int i, input logic [2:0] b, input logic v);
        @(negedge core_clk);
        sfr.addr = addrs[i];
        sfr.bit_sel = b;
        sfr.bit_val = v;
        sfr.bit_wr = 1'b1;
        @(negedge core_clk);
        sfr.bit_wr = 1'b0;
        if (i < 2) begin
            sh[i][b] = v;
            sh[i] = (sh[i] & keep[i]) | ones[i];
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge core_clk);
        sfr.addr = a;
        sfr.rd = 1'b1;
        @(negedge core_clk);
        sfr.rd = 1'b0;
        check(20'(sfr_rdata), 20'(exp), "read");
        check(20'(sfr_hit), 20'(a inside {addrs}), "hit");
    endtask
    // expected groups: pending and mask and global enable, split by priority
    function automatic logic [39:0] exp_req(input logic [NUM_SRC-1:0] p);
        logic [NUM_SRC-1:0] g;
        logic [NUM_SRC-1:0] pr;
        g = p & {sh[3][6:0], sh[2][6:0], sh[0][5:0]} & {NUM_SRC{sh[0][7]}};
        pr = {7'h00, sh[4][6:0], sh[1][5:0]};
        return {g & pr, g & ~pr};
    endfunction
    task automatic pend(input logic [NUM_SRC-1:0] p);
        logic [39:0] e;
        @(negedge core_clk);
        irq_pending = p;
        e = exp_req(p);
        @(negedge core_clk);
        check(req_high, e[39:20], "high group");
        check(req_low, e[19:0], "low group");
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        void'($urandom(32'hcc41a0f1));
        sh = ones;
        repeat (20) @(negedge core_clk);
        srst = 1'b0;
        for (k = 0; k < 5; k++) begin
            rd(addrs[k], sh[k]);
        end
        rd(8'hf7, 8'h00);
        wr(0, 8'h7f);
        wr(2, 8'h7f);
        wr(3, 8'h7f);
        pend('1);
        for (n = 0; n < 60; n++) begin
            k = $urandom_range(4);
            d = 8'($urandom) & ((k == 4) ? 8'h7f : 8'hff);
            slow = 1'($urandom);
            if (n % 4 == 3) begin
                bwr(k, d[2:0], d[3]);
            end else begin
                wr(k, d);
            end
            rd(addrs[k], sh[k]);
            pend(NUM_SRC'($urandom));
        end
        slow = 1'b0;
        wr(0, 8'h00);
        irq_pending = '0;
        for (n = 0; n < 100 && (call_busy || call.start || in_service_high || in_service_low); n++) begin
            @(negedge core_clk);
        end
        wr(1, 8'h01);
        wr(0, 8'h83);
        pend(20'h00002);
        for (n = 1; n < 20 && call.start !== 1'b1; n++) begin
            @(negedge core_clk);
        end
        check(20'(n), 20'd5, "latency");
        check({call.level, 9'h000, call.src, call.order}, {10'h000, 5'h01, 5'h01}, "first call");
        @(negedge core_clk);
        irq_pending = 20'h00003;
        for (n = 0; n < 20 && call.start !== 1'b1; n++) begin
            @(negedge core_clk);
        end
        check({call.level, in_service_low, 13'h0, call.src}, {2'b11, 18'h0}, "preempt");
        @(negedge core_clk);
        srst = 1'b1;
        irq_pending = '0;
        repeat (2) @(negedge core_clk);
        srst = 1'b0;
        sh = ones;
        for (k = 0; k < 5; k++) begin
            rd(addrs[k], sh[k]);
        end
        give_verdict();
    end
endmodule
